// ==== dscec_pkg.sv ====
// Shared constants, field layout, states and carriers of the execution core.
// Assumes single-clock use; memories answer reads within the same cycle.
package dscec_pkg;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int PC_W = 23;
  localparam int INSN_W = 24;
  localparam int DW = 16;
  localparam int NREG = 16;
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [PC_W-1:0] RST_PC = 23'h000000;
  localparam logic [DW-1:0] RST_SP = 16'h0800;
  localparam logic [DW-1:0] STK_STEP = 16'h0002;
  localparam logic [DW-1:0] WORD_STEP = 16'h0002;

  // ------------------------------------------------------------------
  // Major opcodes (insn[23:20]); OP_EXT extends into insn[19:16]
  // ------------------------------------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_GOTO = 4'h1;
  localparam logic [3:0] OP_CALL = 4'h2;
  localparam logic [3:0] OP_ALU = 4'h3;
  localparam logic [3:0] OP_MOVL = 4'h4;
  localparam logic [3:0] OP_MAC = 4'h5;
  localparam logic [3:0] OP_RPT = 4'h6;
  localparam logic [3:0] OP_DO = 4'h7;
  localparam logic [3:0] OP_DIV = 4'h8;
  localparam logic [3:0] OP_MOVD = 4'h9;
  localparam logic [3:0] OP_TBL = 4'ha;
  localparam logic [3:0] OP_EXT = 4'hf;
  localparam logic [1:0] ALU_ADD = 2'h0;
  localparam logic [1:0] ALU_SUB = 2'h1;
  localparam logic [1:0] ALU_AND = 2'h2;
  localparam logic [1:0] ALU_XOR = 2'h3;

  // ------------------------------------------------------------------
  // Timing: divide runs as a repeat of DIV_REPEAT+1 steps
  // ------------------------------------------------------------------
  localparam int DIV_TOTAL_CYC = 19;
  localparam logic [13:0] DIV_REPEAT = 14'(DIV_TOTAL_CYC - 2);
  localparam logic [4:0] DIV_ITER = 5'(DIV_TOTAL_CYC - 1);
  localparam int ACC_W = 40;

  typedef enum logic [5:0] {
    S_EXEC = 6'h01,
    S_PUSH_HI = 6'h02,
    S_POP_LO = 6'h04,
    S_MOVD2 = 6'h08,
    S_TBL = 6'h10
  } dscec_state_t;

  typedef struct packed {
    logic [DW-1:0] raddr;
    logic re;
    logic [DW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic we;
  } dscec_dm_req_t;

endpackage

// ==== dscec_regfile.sv ====
// Working register file: sixteen words, NRD read ports, two write ports.
// Assumes writers never target one register from both ports needlessly.
`timescale 1ns/10ps
`default_nettype none
module dscec_regfile #(
  parameter int NRD = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [NRD-1:0][3:0] rd_idx,
  output logic [NRD-1:0][15:0] rd_data,
  output logic [15:0] sp,
  input wire logic we0,
  input wire logic [3:0] wa0,
  input wire logic [15:0] wd0,
  input wire logic we1,
  input wire logic [3:0] wa1,
  input wire logic [15:0] wd1
);

  logic [15:0] w [dscec_pkg::NREG];

  if (NRD < 1) begin : g_chk
    $error("dscec_regfile needs at least one read port");
  end

  // ------------------------------------------------------------------
  // Storage; port 1 (stack pointer, remainder) wins a collision
  // ------------------------------------------------------------------
  for (genvar g = 0; g < dscec_pkg::NREG; g++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        w[g] <= (4'(g) == dscec_pkg::SP_IDX) ? dscec_pkg::RST_SP : 16'h0000;
      end else if (we1 && wa1 == 4'(g)) begin
        w[g] <= wd1;
      end else if (we0 && wa0 == 4'(g)) begin
        w[g] <= wd0;
      end
    end
  end

  // Read ports are plain muxes so operands arrive in the issue cycle
  for (genvar r = 0; r < NRD; r++) begin : g_rd
    assign rd_data[r] = w[rd_idx[r]];
  end
  assign sp = w[dscec_pkg::SP_IDX];

endmodule
`default_nettype wire

// ==== dscec_core.sv ====
// Execution core: one-word prefetch, sequencer, datapath and loop control.
// Assumes program and data memories answer reads in the same cycle.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Program counter is 23 bits wide
// - 24-bit instruction words, variable-length opcode decode
// - Next word prefetched one cycle ahead
// - One cycle except flow, double move, table
// - Zero-overhead repeat and loop, both interruptible
// - Sixteen working registers of 16 bits
// - Any register is data, pointer or offset
// - Last register is stack pointer for pushes
// - Read, register read, write, fetch per cycle
// - Divide takes 19 cycles, survives interrupts
// - Repeat-active flag readable while repeating
module dscec_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic [22:0] pm_addr,
  input wire logic [23:0] pm_rdata,
  output dscec_pkg::dscec_dm_req_t dm_req,
  input wire logic [15:0] dm_rdata,
  input wire logic irq_req,
  input wire logic [22:0] irq_vector,
  output logic irq_ack,
  output logic [22:0] program_counter,
  output logic [15:0] stack_pointer,
  output logic repeat_active_flag
);

  dscec_pkg::dscec_state_t st;
  logic [23:0] ir;
  logic ir_valid;
  logic [22:0] ir_pc, pc_fetch, tgt;
  logic [6:0] push_hi, pop_hi;
  logic retfie, in_isr;
  logic [13:0] rpt_cnt, sh_cnt, do_cnt;
  logic rpt_act, sh_act, do_act;
  logic [22:0] do_start, do_end;
  logic [dscec_pkg::ACC_W-1:0] acc;
  logic [3:0][3:0] rd_idx;
  logic [3:0][15:0] rd_data;
  logic [15:0] sp;
  logic we0, we1;
  logic [3:0] wa0, wa1;
  logic [15:0] wd0, wd1;

  // ------------------------------------------------------------------
  // Decode: one decoder for both classes, no mode switch
  // ------------------------------------------------------------------
  wire [3:0] op = ir[23:20];
  wire [3:0] fd = ir[15:12];
  wire [3:0] fa = ir[11:8];
  wire [3:0] fb = ir[7:4];
  wire [3:0] fo = ir[3:0];
  wire is_div = op == dscec_pkg::OP_DIV;
  wire issue = st == dscec_pkg::S_EXEC && ir_valid;
  wire irq_take = issue && irq_req && !in_isr;
  wire go = issue && !irq_take;
  wire rep_hold = rpt_act && rpt_cnt != 14'h0000;
  wire single = !(op inside {dscec_pkg::OP_GOTO, dscec_pkg::OP_CALL,
                  dscec_pkg::OP_MOVD, dscec_pkg::OP_TBL,
                  dscec_pkg::OP_EXT});
  // Prefetch refill after a bubble, after each single-cycle issue outside a repeat hold, and in the second double-move cycle
  wire load_ir = (st == dscec_pkg::S_EXEC &&
                  (!ir_valid || (go && single && !rep_hold))) ||
                 st == dscec_pkg::S_MOVD2;
  wire do_hit = do_act && !in_isr && pc_fetch == do_end;
  wire do_wrap = do_hit && do_cnt != 14'h0000;
  wire [22:0] next_fetch = do_wrap ? do_start : pc_fetch + 23'h000001;
  wire [22:0] ret_pc = ir_pc + 23'h000001;

  // Operands: A data, B data or pointer, O offset, D pointer or target
  // Divide pins ports 2/3 onto quotient and remainder registers
  assign rd_idx = {is_div ? 4'h1 : fd, is_div ? 4'h0 : fo, fb, fa};
  wire [15:0] opa = rd_data[0];
  wire [15:0] opb_reg = rd_data[1];
  wire [15:0] src_addr = rd_data[1] + rd_data[2];
  wire [15:0] opb = ir[17] ? dm_rdata : opb_reg;
  wire [15:0] alu_res = (ir[19:18] == dscec_pkg::ALU_ADD) ? opa + opb :
                        (ir[19:18] == dscec_pkg::ALU_SUB) ? opa - opb :
                        (ir[19:18] == dscec_pkg::ALU_AND) ? opa & opb :
                        opa ^ opb;
  wire [31:0] prod = 32'($signed(opa) * $signed(opb_reg));
  // Restoring divide step on quotient W0 and remainder W1
  wire [16:0] rem_sh = {rd_data[3], rd_data[2][15]};
  wire [16:0] rem_dif = rem_sh - {1'b0, opb_reg};
  wire div_init = rpt_act && rpt_cnt == dscec_pkg::DIV_REPEAT;
  wire div_step = rpt_act && !div_init && rpt_cnt != 14'h0000;

  dscec_regfile #(.NRD(4)) u_rf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .sp(sp),
    .we0(we0),
    .wa0(wa0),
    .wd0(wd0),
    .we1(we1),
    .wa1(wa1),
    .wd1(wd1)
  );

  // ------------------------------------------------------------------
  // Datapath writes: registers and data memory per state
  // ------------------------------------------------------------------
  always_comb begin
    we0 = 1'b0;
    wa0 = fd;
    wd0 = alu_res;
    we1 = 1'b0;
    wa1 = dscec_pkg::SP_IDX;
    wd1 = sp + dscec_pkg::STK_STEP;
    dm_req = '0;
    unique case (st)
      dscec_pkg::S_EXEC: begin
        if (irq_take || (go && op == dscec_pkg::OP_CALL)) begin
          dm_req.we = 1'b1;
          dm_req.waddr = sp;
          dm_req.wdata = irq_take ? ir_pc[15:0] : ret_pc[15:0];
          we1 = 1'b1;
        end else if (go) begin
          unique case (op)
            dscec_pkg::OP_ALU: begin
              // Read, register read and write share the cycle
              dm_req.re = ir[17];
              dm_req.raddr = src_addr;
              dm_req.we = ir[16];
              dm_req.waddr = rd_data[3];
              dm_req.wdata = alu_res;
              we0 = !ir[16];
            end
            dscec_pkg::OP_MOVL: begin
              we0 = 1'b1;
              wd0 = ir[15:0];
            end
            dscec_pkg::OP_MAC: begin
              we0 = ir[16];
              wd0 = acc[31:16];
            end
            dscec_pkg::OP_DIV: begin
              // Partial result lives in W0/W1, so a break loses nothing
              we0 = div_init || div_step;
              wa0 = 4'h0;
              wd0 = div_init ? opa :
                    {rd_data[2][14:0], !rem_dif[16]};
              we1 = div_init || div_step;
              wa1 = 4'h1;
              wd1 = div_init ? 16'h0000 :
                    (rem_dif[16] ? rem_sh[15:0] : rem_dif[15:0]);
            end
            dscec_pkg::OP_MOVD: begin
              dm_req.re = 1'b1;
              dm_req.raddr = opa;
              we0 = 1'b1;
              wd0 = dm_rdata;
            end
            dscec_pkg::OP_EXT: begin
              dm_req.re = 1'b1;
              dm_req.raddr = sp - dscec_pkg::STK_STEP;
              we1 = 1'b1;
              wd1 = sp - dscec_pkg::STK_STEP;
            end
            default: ;
          endcase
        end
      end
      dscec_pkg::S_PUSH_HI: begin
        dm_req.we = 1'b1;
        dm_req.waddr = sp;
        dm_req.wdata = {9'h000, push_hi};
        we1 = 1'b1;
      end
      dscec_pkg::S_POP_LO: begin
        dm_req.re = 1'b1;
        dm_req.raddr = sp - dscec_pkg::STK_STEP;
        we1 = 1'b1;
        wd1 = sp - dscec_pkg::STK_STEP;
      end
      dscec_pkg::S_MOVD2: begin
        dm_req.re = 1'b1;
        dm_req.raddr = opa + dscec_pkg::WORD_STEP;
        we0 = 1'b1;
        wa0 = fd + 4'h1;
        wd0 = dm_rdata;
      end
      dscec_pkg::S_TBL: begin
        we0 = 1'b1;
        wd0 = ir[16] ? {8'h00, pm_rdata[23:16]} : pm_rdata[15:0];
      end
      default: ;
    endcase
  end

  // Table reads borrow the fetch port, hence their extra cycles
  assign pm_addr = (st == dscec_pkg::S_TBL) ? {7'h00, opa} : pc_fetch;
  assign program_counter = ir_pc;
  assign stack_pointer = sp;
  assign repeat_active_flag = rpt_act;

  // ------------------------------------------------------------------
  // Sequencer: prefetch, flow change, loops, interrupt entry
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= dscec_pkg::S_EXEC;
      ir <= 24'h000000;
      ir_valid <= 1'b0;
      ir_pc <= dscec_pkg::RST_PC;
      pc_fetch <= dscec_pkg::RST_PC;
      tgt <= dscec_pkg::RST_PC;
      push_hi <= 7'h00;
      pop_hi <= 7'h00;
      retfie <= 1'b0;
      in_isr <= 1'b0;
      {rpt_cnt, sh_cnt, do_cnt} <= '0;
      {rpt_act, sh_act, do_act} <= 3'h0;
      do_start <= dscec_pkg::RST_PC;
      do_end <= dscec_pkg::RST_PC;
      acc <= '0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= irq_take;
      if (load_ir) begin
        ir <= pm_rdata;
        ir_pc <= pc_fetch;
        ir_valid <= 1'b1;
        pc_fetch <= next_fetch;
        if (do_wrap) do_cnt <= do_cnt - 14'h0001;
        else if (do_hit) do_act <= 1'b0;
      end
      unique case (st)
        dscec_pkg::S_EXEC: begin
          if (irq_take) begin
            // Repeat state is parked so the service routine runs plain
            push_hi <= ir_pc[22:16];
            tgt <= irq_vector;
            st <= dscec_pkg::S_PUSH_HI;
            ir_valid <= 1'b0;
            in_isr <= 1'b1;
            sh_cnt <= rpt_cnt;
            sh_act <= rpt_act;
            rpt_act <= 1'b0;
          end else if (go) begin
            if (rpt_act) begin
              if (rep_hold) rpt_cnt <= rpt_cnt - 14'h0001;
              else rpt_act <= 1'b0;
            end
            unique case (op)
              dscec_pkg::OP_GOTO: begin
                pc_fetch <= {3'h0, ir[19:0]};
                ir_valid <= 1'b0;
              end
              dscec_pkg::OP_CALL: begin
                push_hi <= ret_pc[22:16];
                tgt <= {3'h0, ir[19:0]};
                st <= dscec_pkg::S_PUSH_HI;
                ir_valid <= 1'b0;
              end
              dscec_pkg::OP_MAC: acc <= acc + {{8{prod[31]}}, prod};
              dscec_pkg::OP_RPT: begin
                rpt_cnt <= ir[13:0];
                rpt_act <= 1'b1;
              end
              dscec_pkg::OP_DO: begin
                do_act <= 1'b1;
                do_cnt <= ir[13:0];
                do_start <= ret_pc;
                do_end <= ir_pc + 23'h000002 + {17'h00000, ir[19:14]};
              end
              dscec_pkg::OP_MOVD: st <= dscec_pkg::S_MOVD2;
              dscec_pkg::OP_TBL: st <= dscec_pkg::S_TBL;
              dscec_pkg::OP_EXT: begin
                pop_hi <= dm_rdata[6:0];
                retfie <= ir[16];
                st <= dscec_pkg::S_POP_LO;
              end
              default: ;
            endcase
          end
        end
        dscec_pkg::S_PUSH_HI: begin
          pc_fetch <= tgt;
          st <= dscec_pkg::S_EXEC;
        end
        dscec_pkg::S_POP_LO: begin
          pc_fetch <= {pop_hi, dm_rdata};
          ir_valid <= 1'b0;
          st <= dscec_pkg::S_EXEC;
          if (retfie) begin
            in_isr <= 1'b0;
            rpt_cnt <= sh_cnt;
            rpt_act <= sh_act;
          end
        end
        dscec_pkg::S_MOVD2: st <= dscec_pkg::S_EXEC;
        dscec_pkg::S_TBL: begin
          ir_valid <= 1'b0;
          st <= dscec_pkg::S_EXEC;
        end
        default: st <= dscec_pkg::S_EXEC;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Helper: length of each uninterrupted repeat run
  logic [4:0] rpt_len;
  logic rpt_from_div, rpt_broken;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rpt_len <= 5'h00;
      rpt_from_div <= 1'b0;
      rpt_broken <= 1'b0;
    end else if (go && op == dscec_pkg::OP_RPT) begin
      rpt_len <= 5'h00;
      rpt_from_div <= ir[13:0] == dscec_pkg::DIV_REPEAT;
      rpt_broken <= 1'b0;
    end else begin
      if (rpt_act) rpt_len <= rpt_len + 5'h01;
      if (irq_take) rpt_broken <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_push_pair;
    dm_req.we && dm_req.waddr == sp ##1 dm_req.we && st == dscec_pkg::S_PUSH_HI;
  endsequence

  a_div_length: assert property (
    $fell(rpt_act) && rpt_from_div && !rpt_broken |-> rpt_len == dscec_pkg::DIV_ITER)
    else $error("divide repeat run has wrong length");
  a_div_park: assert property (
    irq_take && rpt_act |=> sh_act && sh_cnt == $past(rpt_cnt) && !rpt_act)
    else $error("repeat state not parked on interrupt");
  a_rpt_flag: assert property (
    go && op == dscec_pkg::OP_RPT |=> repeat_active_flag)
    else $error("repeat flag not raised");
  a_flow_flush: assert property (
    go && op == dscec_pkg::OP_GOTO |=> !ir_valid && pm_addr == {3'h0, $past(ir[19:0])}
      ##1 ir_valid && ir_pc == $past(pm_addr))
    else $error("jump did not flush and refetch");
  a_stack_push: assert property (
    irq_take |-> s_push_pair ##1 pm_addr == $past(irq_vector, 2))
    else $error("interrupt entry push or vector wrong");
  a_three_op: assert property (
    go && op == dscec_pkg::OP_ALU && ir[17] && ir[16] && !rep_hold
      |-> dm_req.re && dm_req.we && load_ir && pm_addr == pc_fetch)
    else $error("three-operand cycle not concurrent");
  a_prefetch_word: assert property (
    load_ir |=> ir == $past(pm_rdata) && ir_pc == $past(pc_fetch))
    else $error("prefetched word not taken");
  a_movd_two: assert property (
    go && op == dscec_pkg::OP_MOVD |=> st == dscec_pkg::S_MOVD2 && dm_req.re
      ##1 st == dscec_pkg::S_EXEC && ir_valid)
    else $error("double move not two cycles");
  a_single_cycle: assert property (
    go && op == dscec_pkg::OP_MOVL && !rpt_act && !do_wrap
      |=> ir_valid && ir_pc == $past(pc_fetch) && st == dscec_pkg::S_EXEC)
    else $error("single-cycle instruction stalled");

endmodule
`default_nettype wire

// ==== dscec_mem_model.sv ====
// Behavioural program and data memories facing the execution core.
// Assumes the bench preloads both arrays while the core is held in reset.
`timescale 1ns/10ps
`default_nettype none
module dscec_mem_model (
  input wire logic clk_sys,
  input wire logic [22:0] pm_addr,
  output logic [23:0] pm_rdata,
  input wire dscec_pkg::dscec_dm_req_t dm_req,
  output logic [15:0] dm_rdata
);
  // ----------------------------------------------------------------
  // Arrays and ports
  // ----------------------------------------------------------------
  logic [23:0] pm [0:255];
  logic [15:0] dm [0:2047];
  // Same-cycle reads; program space aliases above 256 words
  assign pm_rdata = pm[pm_addr[7:0]];
  // Idle read port toggles, so a stale value is never mistaken for data
  assign dm_rdata = dm_req.re ? dm[dm_req.raddr[11:1]] :
                    ({16{clk_sys}} ^ 16'h5a5a);
  // Separate write port lets a read and a write share one cycle
  // Plain always: the bench also preloads this array during reset
  always @(posedge clk_sys) begin
    if (dm_req.we) begin
      dm[dm_req.waddr[11:1]] <= dm_req.wdata;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the execution core with behavioural memories.
// Assumes programs are loaded while reset is held, then traced 64 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_sys;
  logic rst_n;
  logic [22:0] pm_addr;
  logic [23:0] pm_rdata;
  dscec_pkg::dscec_dm_req_t dm_req;
  logic [15:0] dm_rdata;
  logic irq_req;
  logic [22:0] irq_vector;
  logic irq_ack;
  logic [22:0] program_counter;
  logic [15:0] stack_pointer;
  logic repeat_active_flag;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [22:0] pc_tr [0:63];
  logic [22:0] pa_tr [0:63];
  logic [15:0] sp_tr [0:63];
  logic [15:0] wd_tr [0:63];
  logic fl_tr [0:63];
  logic ak_tr [0:63];
  logic we_tr [0:63];

  // ----------------------------------------------------------------
  // Design, memories, clock
  // ----------------------------------------------------------------
  dscec_core DUT (.clk_sys(clk_sys), .rst_n(rst_n), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .program_counter(program_counter), .stack_pointer(stack_pointer),
    .repeat_active_flag(repeat_active_flag));
  dscec_mem_model MEM (.clk_sys(clk_sys), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata));

  // 50 MHz clock and time-zero input values
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    irq_req = 1'b0;
    irq_vector = 23'h000030;
    forever #10 clk_sys = ~clk_sys;
  end

  // Hang guard: far above the few hundred cycles the scenarios need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Miss gives a mid-trace index so the following compares fail
  function automatic int first_pc(input logic [22:0] v);
    for (int i = 0; i < 64; i++) begin
      if (pc_tr[i] === v) return i;
    end
    return 32;
  endfunction

  // Hold reset 8 cycles, clear memories, check reset outputs
  task automatic prep();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    irq_req <= 1'b0;
    for (int i = 0; i < 256; i++) MEM.pm[i] = 24'h000000;
    for (int i = 0; i < 2048; i++) MEM.dm[i] = 16'h0000;
    repeat (8) @(posedge clk_sys);
    #1;
    check(program_counter, 0);
    check(pm_addr, 0);
    check(stack_pointer, 16'h0800);
    check(repeat_active_flag, 0);
    check(irq_ack, 0);
    check(dm_req.we, 0);
  endtask

  // Release reset, optionally raise an interrupt, trace 64 cycles
  task automatic run(input int irq_at);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      rst_n <= 1'b1;
      if (i == irq_at) irq_req <= 1'b1;
      if (i > 0 && ak_tr[i-1] === 1'b1) irq_req <= 1'b0;
      #1;
      pc_tr[i] = program_counter;
      pa_tr[i] = pm_addr;
      sp_tr[i] = stack_pointer;
      wd_tr[i] = dm_req.wdata;
      we_tr[i] = dm_req.we;
      fl_tr[i] = repeat_active_flag;
      ak_tr[i] = irq_ack;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Pointer, offset and data use back to back, memory in and out
  task automatic t_alu();
    int k;
    prep();
    MEM.pm[0] = 24'h902f00;
    MEM.pm[1] = 24'h333223;
    MEM.pm[2] = 24'h3d3233;
    MEM.pm[3] = 24'h100003;
    MEM.dm[11'h400] = 16'h0100;
    MEM.dm[11'h401] = 16'h0004;
    MEM.dm[11'h082] = 16'h1234;
    run(-1);
    k = first_pc(23'h000001);
    check(we_tr[k], 1);
    check(wd_tr[k], 16'h1334);
    check(pa_tr[k], 23'h000002);
    check(pc_tr[k+1], 23'h000002);
    check(wd_tr[k+1], 16'h0104);
    check(MEM.dm[2], 16'h0104);
  endtask

  // Jump into the upper address bits; one bubble, then refetch
  task automatic t_goto();
    int k;
    prep();
    MEM.pm[0] = 24'h180010;
    MEM.pm[16] = 24'h180010;
    run(-1);
    k = first_pc(23'h080010);
    check(pc_tr[k-2], 0);
    check(pa_tr[k-1], 23'h080010);
    check(pa_tr[k], 23'h080011);
  endtask

  // Call from a high address; both return words go on the stack
  task automatic t_call();
    int c;
    int k;
    int j;
    prep();
    MEM.pm[0] = 24'h180010;
    MEM.pm[16] = 24'h200020;
    MEM.pm[17] = 24'h180011;
    MEM.pm[32] = 24'hf00000;
    run(-1);
    c = first_pc(23'h080010);
    k = first_pc(23'h000020);
    j = first_pc(23'h080011);
    check(k - c, 3);
    check(j - k, 3);
    check(sp_tr[k], 16'h0804);
    check(sp_tr[j], 16'h0800);
    check(MEM.dm[11'h400], 16'h0011);
    check(MEM.dm[11'h401], 16'h0008);
  endtask

  // 100 / 6 under repeat, plain or broken by an interrupt
  task automatic t_div(input int irq_at);
    int nf;
    int na;
    prep();
    MEM.pm[0] = 24'h902f00;
    MEM.pm[1] = 24'h600011;
    MEM.pm[2] = 24'h800230;
    MEM.pm[3] = 24'h393000;
    MEM.pm[4] = 24'h392110;
    MEM.pm[5] = 24'h100005;
    MEM.pm[48] = 24'hf10000;
    MEM.dm[11'h400] = 16'h0064;
    MEM.dm[11'h401] = 16'h0006;
    run(irq_at);
    nf = 0;
    na = 0;
    for (int i = 0; i < 64; i++) begin
      if (fl_tr[i] === 1'b1) nf++;
      if (ak_tr[i] === 1'b1) na++;
    end
    check(MEM.dm[3], 16'h0010);
    check(MEM.dm[50], 16'h0004);
    if (irq_at < 0) begin
      check(first_pc(3) - first_pc(1), 19);
      check(nf, 18);
      check(fl_tr[first_pc(1)], 0);
    end else begin
      check(na, 1);
      check(MEM.dm[11'h400], 16'h0002);
      check(first_pc(23'h000030) < 32, 1);
    end
  endtask

  // Immediates, table read, counted loop with multiply-accumulate
  task automatic t_misc();
    prep();
    MEM.pm[0] = 24'h404001;
    MEM.pm[1] = 24'h401040;
    MEM.pm[2] = 24'h403004;
    MEM.pm[3] = 24'h405002;
    MEM.pm[4] = 24'ha02100;
    MEM.pm[5] = 24'h390220;
    MEM.pm[6] = 24'h700002;
    MEM.pm[7] = 24'h301140;
    MEM.pm[8] = 24'h500440;
    MEM.pm[9] = 24'h516440;
    MEM.pm[10] = 24'h395110;
    MEM.pm[11] = 24'h393660;
    MEM.pm[12] = 24'h10000c;
    MEM.pm[64] = 24'h12abcd;
    run(-1);
    check(first_pc(2) - first_pc(1), 1);
    check(first_pc(5) - first_pc(4), 3);
    check(first_pc(9) - first_pc(6), 7);
    check(MEM.dm[0], 16'habcd);
    check(MEM.dm[1], 16'hd043);
    check(MEM.dm[2], 16'h3001);
  endtask

  // Main sequence
  initial begin
    t_alu();
    t_misc();
    t_goto();
    t_call();
    t_div(-1);
    t_div(8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
